// [timer_defs.svh]
// Purpose: named constants for the interval timer block
// Assumes: 8-bit I/O data, F0 index space selected by a flag
// Notes:   definitions only
`ifndef TIMER_DEFS_SVH
`define TIMER_DEFS_SVH

// i/o space addresses
`define IO_CNT_BASE     6'h10
`define IO_CNT_CMD      2'h3
`define IO_PORT_B       8'h61
// configuration index space addresses
`define CFG_CTRL        8'h50
`define CFG_SHADOW      8'hBA
// reset values and unmapped read data
`define CTRL_RST        8'h7B
`define PORTB_RST       4'hC
`define UNMAPPED_DATA   8'hFF
// control register fields
`define CTRL_SRST       7
`define CTRL_PASS1      6
`define CTRL_COUNTER1_GATE      5
`define CTRL_PASS0      4
`define CTRL_COUNTER0_GATE      3
// port b fields
`define PB_COUNTER2_GATE        0
`define PB_SPK          1
// oscillator divider, twelve oscillator rises per tick
`define OSC_DIV_LAST    4'hB
// shadow pointer
`define SHADOW_LAST     4'h8
`define SHADOW_CMD0     4'h6
// command word fields
`define CMD_SEL_HI      7
`define CMD_SEL_LO      6
`define CMD_RW_HI       5
`define CMD_RW_LO       4
`define CMD_RST         8'h00

`endif

// [timer_pkg.sv]
// Purpose: types shared by the interval timer block
// Assumes: timer_defs.svh for numeric constants
// Notes:   nothing is imported by users
package timer_pkg;

    typedef struct packed {
        logic       rd;
        logic       wr;
        logic       cfg;
        logic [7:0] addr;
        logic [7:0] wdata;
    } io_req_t;

    typedef enum logic [2:0] {
        MODE_INT  = 3'h0,
        MODE_ONE  = 3'h1,
        MODE_RATE = 3'h2,
        MODE_SQR  = 3'h3,
        MODE_SWS  = 3'h4,
        MODE_HWS  = 3'h5
    } mode_t;

    typedef enum logic [1:0] {
        RW_LATCH = 2'h0,
        RW_LSB   = 2'h1,
        RW_MSB   = 2'h2,
        RW_BOTH  = 2'h3
    } rw_t;

endpackage : timer_pkg

// [timer_channel.sv]
// Purpose: one interval counter with command word, reload and byte access
// Assumes: i_tick is a one-cycle enable at the counter rate
// Notes:   binary counting only; the bcd bit is stored but not used
`timescale 1ns/1ps
`include "timer_defs.svh"
module timer_channel (
    input  wire logic        i_clk,
    input  wire logic        i_sys_rst,
    input  wire logic        i_clr,
    input  wire logic        i_tick,
    input  wire logic        i_gate,
    input  wire logic        i_cmd_wr,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    input  wire logic [7:0]  i_wdata,
    output logic             o_out,
    output logic [7:0]       o_rdata,
    output logic [15:0]      o_base,
    output logic [15:0]      o_count,
    output logic [7:0]       o_cmd
);
    function automatic timer_pkg::mode_t eff_mode(input logic [7:0] c);
        logic [2:0] m;
        m = c[3:1];
        if (m[2:1] == 2'b11) m = {1'b0, m[1:0]};
        return timer_pkg::mode_t'(m);
    endfunction : eff_mode

    logic [7:0]  cmd_q;
    logic [15:0] base_q, count_q, latch_q;
    logic        latched_q, wr_hi_q, rd_hi_q, load_q;
    logic        armed_q, out_q, gate_prev_q, trig_q;

    wire timer_pkg::mode_t mode    = eff_mode(cmd_q);
    wire timer_pkg::rw_t   rw      = timer_pkg::rw_t'(cmd_q[`CMD_RW_HI:`CMD_RW_LO]);
    wire                   new_cmd = i_cmd_wr && (i_wdata[`CMD_RW_HI:`CMD_RW_LO] != 2'h0);
    wire                   wr_done = i_wr && (rw != timer_pkg::RW_BOTH || wr_hi_q);
    wire                   hw_mode = (mode == timer_pkg::MODE_ONE) || (mode == timer_pkg::MODE_HWS);
    wire                   trig_md = hw_mode || mode == timer_pkg::MODE_RATE || mode == timer_pkg::MODE_SQR;
    wire                   do_load = i_tick && load_q && (!hw_mode || trig_q);
    wire                   reload  = do_load || (i_tick && trig_q && trig_md);
    wire                   run     = i_tick && armed_q && (i_gate || hw_mode);
    wire [15:0]            rsrc    = latched_q ? latch_q : count_q;
    wire                   rhi     = (rw == timer_pkg::RW_MSB) || (rw == timer_pkg::RW_BOTH && rd_hi_q);

    // command, byte pointers, base value and latch
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            cmd_q <= `CMD_RST; base_q <= 16'h0000; latch_q <= 16'h0000;
            latched_q <= 1'b0; wr_hi_q <= 1'b0; rd_hi_q <= 1'b0; load_q <= 1'b0;
        end else if (i_clr) begin
            cmd_q <= `CMD_RST; base_q <= 16'h0000; latch_q <= 16'h0000;
            latched_q <= 1'b0; wr_hi_q <= 1'b0; rd_hi_q <= 1'b0; load_q <= 1'b0;
        end else begin
            if (do_load) load_q <= 1'b0;
            if (new_cmd) begin
                cmd_q <= i_wdata; wr_hi_q <= 1'b0; rd_hi_q <= 1'b0;
                latched_q <= 1'b0; load_q <= 1'b0;
            end else if (i_cmd_wr && !latched_q) begin
                latch_q <= count_q; latched_q <= 1'b1;
            end else if (i_wr) begin
                if (rw == timer_pkg::RW_LSB || (rw == timer_pkg::RW_BOTH && !wr_hi_q)) base_q[7:0] <= i_wdata;
                else base_q[15:8] <= i_wdata;
                if (rw == timer_pkg::RW_BOTH) wr_hi_q <= ~wr_hi_q;
                if (wr_done) load_q <= 1'b1;
            end else if (i_rd) begin
                if (rw == timer_pkg::RW_BOTH) rd_hi_q <= ~rd_hi_q;
                if (rw != timer_pkg::RW_BOTH || rd_hi_q) latched_q <= 1'b0;
            end
        end
    end

    // counting per mode
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            count_q <= 16'h0000; armed_q <= 1'b0; out_q <= 1'b0; gate_prev_q <= 1'b0; trig_q <= 1'b0;
        end else if (i_clr) begin
            count_q <= 16'h0000; armed_q <= 1'b0; out_q <= 1'b0; gate_prev_q <= 1'b0; trig_q <= 1'b0;
        end else begin
            gate_prev_q <= i_gate;
            if (i_tick) trig_q <= 1'b0;
            if (i_gate && !gate_prev_q) trig_q <= 1'b1;
            if (new_cmd) begin
                out_q   <= (eff_mode(i_wdata) != timer_pkg::MODE_INT);
                armed_q <= 1'b0;
            end else if (wr_done && mode == timer_pkg::MODE_INT) begin
                out_q <= 1'b0;
            end else if (!i_gate && (mode == timer_pkg::MODE_RATE || mode == timer_pkg::MODE_SQR)) begin
                out_q <= 1'b1;
            end else if (reload) begin
                count_q <= base_q;
                armed_q <= 1'b1;
                if (mode == timer_pkg::MODE_ONE) out_q <= 1'b0;
                if (mode == timer_pkg::MODE_RATE || mode == timer_pkg::MODE_SQR) out_q <= 1'b1;
            end else if (run) begin
                unique case (mode)
                    timer_pkg::MODE_INT, timer_pkg::MODE_ONE: begin
                        if (count_q == 16'h0001) out_q <= 1'b1;
                        count_q <= count_q - 16'h0001;
                    end
                    timer_pkg::MODE_RATE: begin
                        if (count_q == 16'h0002) out_q <= 1'b0;
                        if (count_q == 16'h0001) begin
                            out_q <= 1'b1; count_q <= base_q;
                        end else count_q <= count_q - 16'h0001;
                    end
                    timer_pkg::MODE_SQR: begin
                        if (count_q <= 16'h0002) begin
                            out_q <= ~out_q; count_q <= base_q;
                        end else count_q <= count_q - 16'h0002;
                    end
                    timer_pkg::MODE_SWS, timer_pkg::MODE_HWS: begin
                        if (count_q == 16'h0001) out_q <= 1'b0;
                        if (!out_q) begin
                            out_q <= 1'b1; armed_q <= 1'b0;
                        end
                        count_q <= count_q - 16'h0001;
                    end
                    default: count_q <= count_q;
                endcase
            end
        end
    end

    assign o_out   = out_q;
    assign o_rdata = rhi ? rsrc[15:8] : rsrc[7:0];
    assign o_base  = base_q;
    assign o_count = count_q;
    assign o_cmd   = cmd_q;
endmodule : timer_channel

// [interval_timer_block.sv]
// Purpose: three-channel interval timer with gating, port b and shadow port
// Assumes: i_io is a one-cycle I/O or configuration access, synchronous to i_clk
// Notes:   read data returns one cycle after the read strobe
//
// What this block does
// - three counters tick at oscillator divided by twelve, each with own mode.
// - counter 2 gate follows port b bit 0.
// - counter 0 output drives system timer irq, forced zero when control bit 4 clear.
// - counter 0 gate follows control register bit 3.
// - counter 1 gate follows control register bit 5.
// - control bit 6 clear forces counter 1 output to zero before toggle.
// - port b bit 4 resets to 0, flips on each falling gated counter 1 edge.
// - beep output is counter 2 output and port b bit 1.
// - port b bit 5 reads counter 2 output level.
// - control bit 7 set holds the three counters in reset; divider, toggle and shadow pointer keep running.
// - shadow port pointer starts at entry 0, reads advance, writes return it.
// - shadow order is base bytes of counters 0..2 then their command words.
// - shadowed count bytes are the programmed base, not the live count.
`timescale 1ns/1ps
`include "timer_defs.svh"
module interval_timer_block (
    input  wire logic              i_clk,
    input  wire logic              i_sys_rst,
    input  wire logic              i_oscillator_input,
    input  wire timer_pkg::io_req_t i_io,
    output logic [7:0]             o_io_rdata,
    output logic                   o_io_rvalid,
    output logic                   o_system_timer_irq,
    output logic                   o_beep_output
);
    logic       osc_prev_q;
    logic [3:0] osc_div_q;
    logic       tick_q;
    logic [7:0] ctrl_q;
    logic [3:0] portb_q;
    logic [3:0] shadow_ptr_q;
    logic       toggle_q;
    logic       gated1_prev_q;
    logic [7:0] rdata_q;
    logic       rvalid_q;
    logic       irq_q;
    logic       beep_q;

    logic [2:0]       chan_out;
    logic [2:0][7:0]  chan_rdata;
    logic [2:0][15:0] chan_base;
    logic [2:0][15:0] chan_count;
    logic [2:0][7:0]  chan_cmd;

    // oscillator divide by twelve
    wire osc_rise  = i_oscillator_input && !osc_prev_q;
    wire osc_wrap  = osc_rise && (osc_div_q == `OSC_DIV_LAST);

    // address decode
    wire       sel_cnt   = !i_io.cfg && (i_io.addr[7:2] == `IO_CNT_BASE);
    wire       sel_cmd   = sel_cnt && (i_io.addr[1:0] == `IO_CNT_CMD);
    wire       sel_portb = !i_io.cfg && (i_io.addr == `IO_PORT_B);
    wire       sel_ctrl  = i_io.cfg && (i_io.addr == `CFG_CTRL);
    wire       sel_shad  = i_io.cfg && (i_io.addr == `CFG_SHADOW);
    wire       cmd_wr    = i_io.wr && sel_cmd;
    wire [1:0] cmd_sel   = i_io.wdata[`CMD_SEL_HI:`CMD_SEL_LO];
    wire       shad_rd   = i_io.rd && sel_shad;
    wire       shad_wr   = i_io.wr && sel_shad;
    wire       timer_clr = ctrl_q[`CTRL_SRST];

    // gates and output masking
    wire [2:0] chan_gate = {portb_q[`PB_COUNTER2_GATE], ctrl_q[`CTRL_COUNTER1_GATE], ctrl_q[`CTRL_COUNTER0_GATE]};
    wire       gated1    = chan_out[1] && ctrl_q[`CTRL_PASS1];
    wire       irq_d     = chan_out[0] && ctrl_q[`CTRL_PASS0];
    wire       beep_d    = chan_out[2] && portb_q[`PB_SPK];
    wire [7:0] portb_rd  = {2'b00, chan_out[2], toggle_q, portb_q};

    // shadow entry select: base bytes first, then command words
    wire [1:0] shad_chan  = shadow_ptr_q[2:1];
    wire [1:0] shad_cidx  = 2'(shadow_ptr_q - `SHADOW_CMD0);
    wire [7:0] shad_byte  = (shadow_ptr_q < `SHADOW_CMD0)
                          ? (shadow_ptr_q[0] ? chan_base[shad_chan][15:8] : chan_base[shad_chan][7:0])
                          : chan_cmd[shad_cidx];
    wire [3:0] shad_next  = (shadow_ptr_q == `SHADOW_LAST) ? 4'h0 : 4'(shadow_ptr_q + 4'h1);

    wire [7:0] rdata_d = sel_cnt && !sel_cmd ? chan_rdata[i_io.addr[1:0]]
                       : sel_portb           ? portb_rd
                       : sel_ctrl            ? ctrl_q
                       : sel_shad            ? shad_byte
                       : `UNMAPPED_DATA;

    generate
        for (genvar g = 0; g < 3; g++) begin : g_chan
            timer_channel u_chan (
                .i_clk     (i_clk),
                .i_sys_rst (i_sys_rst),
                .i_clr     (timer_clr),
                .i_tick    (tick_q),
                .i_gate    (chan_gate[g]),
                .i_cmd_wr  (cmd_wr && cmd_sel == 2'(g)),
                .i_wr      (i_io.wr && sel_cnt && !sel_cmd && i_io.addr[1:0] == 2'(g)),
                .i_rd      (i_io.rd && sel_cnt && !sel_cmd && i_io.addr[1:0] == 2'(g)),
                .i_wdata   (i_io.wdata),
                .o_out     (chan_out[g]),
                .o_rdata   (chan_rdata[g]),
                .o_base    (chan_base[g]),
                .o_count   (chan_count[g]),
                .o_cmd     (chan_cmd[g])
            );
        end
    endgenerate

    // counter tick enable
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            osc_prev_q <= 1'b0;
            osc_div_q  <= 4'h0;
            tick_q     <= 1'b0;
        end else begin
            osc_prev_q <= i_oscillator_input;
            tick_q     <= osc_wrap;
            if (osc_rise) osc_div_q <= osc_wrap ? 4'h0 : 4'(osc_div_q + 4'h1);
        end
    end

    // control and port b registers
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            ctrl_q  <= `CTRL_RST;
            portb_q <= `PORTB_RST;
        end else begin
            if (i_io.wr && sel_ctrl) ctrl_q <= i_io.wdata;
            if (i_io.wr && sel_portb) portb_q <= i_io.wdata[3:0];
        end
    end

    // shadow pointer
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) shadow_ptr_q <= 4'h0;
        else if (shad_wr) shadow_ptr_q <= 4'h0;
        else if (shad_rd) shadow_ptr_q <= shad_next;
    end

    // counter 1 toggle on falling gated output
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            gated1_prev_q <= 1'b0;
            toggle_q      <= 1'b0;
        end else begin
            gated1_prev_q <= gated1;
            if (gated1_prev_q && !gated1) toggle_q <= ~toggle_q;
        end
    end

    // registered outputs
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            irq_q    <= 1'b0;
            beep_q   <= 1'b0;
            rdata_q  <= 8'h00;
            rvalid_q <= 1'b0;
        end else begin
            irq_q    <= irq_d;
            beep_q   <= beep_d;
            rvalid_q <= i_io.rd;
            if (i_io.rd) rdata_q <= rdata_d;
        end
    end

    assign o_io_rdata         = rdata_q;
    assign o_io_rvalid        = rvalid_q;
    assign o_system_timer_irq = irq_q;
    assign o_beep_output      = beep_q;

    // checks
    tick_rate_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        osc_wrap |=> tick_q ##1 !tick_q)
        else $error("tick missing after twelfth oscillator rise");
    tick_only_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        tick_q |-> $past(osc_rise) && $past(osc_div_q) == `OSC_DIV_LAST)
        else $error("tick without divider wrap");
    irq_mask_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        !ctrl_q[`CTRL_PASS0] |=> !o_system_timer_irq)
        else $error("system timer irq not masked");
    irq_follow_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (ctrl_q[`CTRL_PASS0] && chan_out[0]) |=> o_system_timer_irq)
        else $error("system timer irq lost");
    beep_gate_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        o_beep_output |-> $past(portb_q[`PB_SPK]) && $past(chan_out[2]))
        else $error("beep output without enable and counter 2");
    toggle_flip_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        $fell(gated1) |=> toggle_q != $past(toggle_q, 2))
        else $error("toggle did not flip");
    toggle_hold_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        !ctrl_q[`CTRL_PASS1] ##1 !ctrl_q[`CTRL_PASS1] |=> $stable(toggle_q))
        else $error("toggle moved while counter 1 masked");
    shadow_step_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (shad_rd && !shad_wr && shadow_ptr_q < `SHADOW_LAST) |=> shadow_ptr_q == $past(shadow_ptr_q) + 4'h1)
        else $error("shadow pointer did not advance");
    shadow_clear_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        shad_wr |=> shadow_ptr_q == 4'h0)
        else $error("shadow pointer not returned by write");
    shadow_base_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (i_io.rd && sel_shad && shadow_ptr_q == 4'h0) |=> o_io_rdata == $past(chan_base[0][7:0]))
        else $error("shadow byte is not the base value");
    soft_reset_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        timer_clr |=> chan_count[0] == 16'h0000 && chan_cmd[1] == `CMD_RST && !chan_out[2])
        else $error("timer not held in reset");
    port_b_read_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (i_io.rd && sel_portb) |=> o_io_rdata[5] == $past(chan_out[2]))
        else $error("port b bit 5 does not show counter 2");

    irq_pulse_c: cover property (@(posedge i_clk) disable iff (i_sys_rst) $rose(o_system_timer_irq));
    toggle_c: cover property (@(posedge i_clk) disable iff (i_sys_rst) $changed(toggle_q));
    beep_c: cover property (@(posedge i_clk) disable iff (i_sys_rst) $rose(o_beep_output));
    shadow_wrap_c: cover property (@(posedge i_clk) disable iff (i_sys_rst)
        shad_rd && shadow_ptr_q == `SHADOW_LAST);
endmodule : interval_timer_block

// [host_io_model.sv]
// Purpose: host model issuing one-cycle i/o and configuration accesses
// Assumes: read answer pulses on o_io_rvalid the cycle after the strobe
// Notes:   requests change 1 ns after the rising edge
`timescale 1ns/1ps
module host_io_model (
    input  wire logic          i_clk,
    input  wire logic [7:0]    i_rdata,
    input  wire logic          i_rvalid,
    output timer_pkg::io_req_t o_io
);
    initial begin
        o_io = '0;
    end

    // one write strobe, no answer expected
    task automatic wr(input logic cfg, input logic [7:0] addr, input logic [7:0] data);
        @(posedge i_clk);
        #1 o_io = '{rd: 1'b0, wr: 1'b1, cfg: cfg, addr: addr, wdata: data};
        @(posedge i_clk);
        #1 o_io = '0;
    endtask : wr

    // one read strobe, data taken while the answer stands
    task automatic rd(input logic cfg, input logic [7:0] addr, output logic [7:0] data);
        int k;
        data = 8'hXX;
        @(posedge i_clk);
        #1 o_io = '{rd: 1'b1, wr: 1'b0, cfg: cfg, addr: addr, wdata: 8'h00};
        @(posedge i_clk);
        #1 o_io = '0;
        for (k = 0; k < 3 && i_rvalid !== 1'b1; k++) begin
            @(posedge i_clk);
            #1;
        end
        if (i_rvalid === 1'b1) begin
            data = i_rdata;
        end
    endtask : rd
endmodule : host_io_model

// [interval_timer_block_bench.sv]
// Purpose: self-checking bench for the interval timer block
// Assumes: oscillator toggles every clock, so one counter tick is 24 clocks
// Notes:   accesses go through the host model
`timescale 1ns/1ps
`include "timer_defs.svh"
`define CHK(nm, exp, got) begin checks_done++; if ((got) !== (exp)) begin mismatches++; \
    $display("Error %s expected %0h seen %0h", nm, exp, got); end end
module interval_timer_block_bench;
    logic               clk;
    logic               rst;
    logic               osc;
    timer_pkg::io_req_t io_req;
    logic [7:0]         rdata;
    logic               rvalid;
    logic               irq;
    logic               beep;
    int                 mismatches;
    int                 checks_done;
    int                 cycles;
    int                 len;
    int                 n;
    logic [7:0]         d;
    logic [7:0]         shadow_exp [9] = '{8'h04, 8'h00, 8'h05, 8'h00, 8'h06, 8'h00, 8'h36, 8'h74, 8'hB6};

    interval_timer_block uut (.i_clk(clk), .i_sys_rst(rst), .i_oscillator_input(osc), .i_io(io_req),
        .o_io_rdata(rdata), .o_io_rvalid(rvalid), .o_system_timer_irq(irq), .o_beep_output(beep));
    host_io_model host (.i_clk(clk), .i_rdata(rdata), .i_rvalid(rvalid), .o_io(io_req));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    always @(posedge clk) begin
        osc <= #1 ~osc;
        cycles++;
        if (cycles == 30000) begin
            mismatches++;
            wrap_up();
        end
    end

    function automatic logic sig(input int sel);
        return (sel != 0) ? beep : irq;
    endfunction : sig

    // cycles of the next high phase, 0 if it never rises
    task automatic pulse_len(input int sel, output int len);
        int k;
        len = 0;
        for (k = 0; k < 400 && sig(sel) !== 1'b0; k++) @(posedge clk) #1;
        for (k = 0; k < 400 && sig(sel) !== 1'b1; k++) @(posedge clk) #1;
        for (k = 0; k < 400 && sig(sel) === 1'b1; k++) begin
            @(posedge clk) #1;
            len++;
        end
    endtask : pulse_len

    // changes of the port b toggle over 300 reads
    task automatic toggle_flips(output int flips);
        logic [7:0] a;
        logic [7:0] b;
        flips = 0;
        host.rd(1'b0, `IO_PORT_B, a);
        repeat (300) begin
            host.rd(1'b0, `IO_PORT_B, b);
            if (b[4] !== a[4]) flips++;
            a = b;
        end
    endtask : toggle_flips

    task automatic wrap_up();
        if (mismatches == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : wrap_up

    initial begin
        rst = 1'b1;
        osc = 1'b0;
        mismatches = 0;
        checks_done = 0;
        cycles = 0;
        repeat (2) @(posedge clk);
        #1 rst = 1'b0;
        host.rd(1'b1, `CFG_CTRL, d);
        `CHK("ctrl reset", 8'h7B, d)
        host.rd(1'b0, `IO_PORT_B, d);
        `CHK("port b reset", 8'h0C, d)
        host.rd(1'b1, 8'h51, d);
        `CHK("unmapped read", 8'hFF, d)
        for (n = 0; n < 9; n++) begin
            host.rd(1'b1, `CFG_SHADOW, d);
            `CHK("shadow reset", 8'h00, d)
        end
        // counter 0 square wave, counter 1 rate, counter 2 square wave
        host.wr(1'b0, 8'h43, 8'h36);
        host.wr(1'b0, 8'h40, 8'h04);
        host.wr(1'b0, 8'h40, 8'h00);
        host.wr(1'b0, 8'h43, 8'h74);
        host.wr(1'b0, 8'h41, 8'h05);
        host.wr(1'b0, 8'h41, 8'h00);
        host.wr(1'b0, 8'h43, 8'hB6);
        host.wr(1'b0, 8'h42, 8'h06);
        host.wr(1'b0, 8'h42, 8'h00);
        host.rd(1'b1, `CFG_SHADOW, d);
        host.rd(1'b1, `CFG_SHADOW, d);
        host.wr(1'b1, `CFG_SHADOW, 8'h00);
        for (n = 0; n < 10; n++) begin
            host.rd(1'b1, `CFG_SHADOW, d);
            `CHK("shadow entry", shadow_exp[n % 9], d)
        end
        pulse_len(0, len);
        `CHK("irq high time", 48, len)
        host.wr(1'b1, `CFG_CTRL, 8'h6B);
        pulse_len(0, len);
        `CHK("irq masked", 0, len)
        host.wr(1'b1, `CFG_CTRL, 8'h73);
        pulse_len(0, len);
        `CHK("irq counter0_gate low", 1'b1, len != 48)
        host.wr(1'b1, `CFG_CTRL, 8'h7B);
        host.wr(1'b0, `IO_PORT_B, 8'hF3);
        host.rd(1'b0, `IO_PORT_B, d);
        `CHK("port b stored bits", 8'h03, d & 8'hCF)
        pulse_len(1, len);
        `CHK("beep high time", 72, len)
        host.rd(1'b0, `IO_PORT_B, d);
        `CHK("counter2_output level low", 1'b0, d[5])
        for (n = 0; n < 400 && beep !== 1'b1; n++) @(posedge clk) #1;
        host.rd(1'b0, `IO_PORT_B, d);
        `CHK("counter2_output level high", 1'b1, d[5])
        host.wr(1'b0, `IO_PORT_B, 8'h01);
        pulse_len(1, len);
        `CHK("beep masked", 0, len)
        host.wr(1'b0, `IO_PORT_B, 8'h02);
        pulse_len(1, len);
        `CHK("beep counter2_gate low", 1'b1, len != 72)
        toggle_flips(n);
        `CHK("toggle runs", 1'b1, n >= 3)
        host.wr(1'b1, `CFG_CTRL, 8'h3B);
        toggle_flips(n);
        `CHK("toggle masked", 0, n)
        host.wr(1'b1, `CFG_CTRL, 8'h5B);
        toggle_flips(n);
        `CHK("toggle counter1_gate low", 0, n)
        host.wr(1'b1, `CFG_CTRL, 8'hFB);
        pulse_len(0, len);
        `CHK("irq in soft reset", 0, len)
        host.rd(1'b1, `CFG_CTRL, d);
        `CHK("ctrl kept in soft reset", 8'hFB, d)
        wrap_up();
    end
endmodule : interval_timer_block_bench
